//--- hw/tml1_regs.v
// time measurement capability and l1 substate timing register bank
// Function
// R1 - header bits 15:0 read 001fh
// R2 - header version field reads one
// R3 - next capability pointer reads zero
// R4 - requester, responder, root role bits read one
// R5 - local tick period read-only, resets zero
// R6 - exchanges take part only while enabled
// R7 - root role needs select and enable
// R8 - accuracy field stored, affects nothing
// R9 - release clock request on L1.1 entry
// R10 - line released only when both release
// R11 - wait expiry: drive again, back to L1
// R12 - wait field in 10 ns units, resets 0fffh
// R13 - software entry delay, 4 ns units
// R14 - hardware entry delay, 4 ns units
// R15 - capability registers only in upstream port
// R16 - timers restart on each new entry
`timescale 1ns/10ps
`include "tml1_consts.vh"
module tml1_regs
#(
  parameter [19:0] WAIT_RESET = `TML1_CRW_RST // wait field reset value
)
(
  input  wire        ref_clk,           // core clock, 200 MHz
  input  wire        rst,               // async reset, active high
  input  wire [11:0] reg_addr,          // register byte address
  input  wire [31:0] reg_wdata,         // write data
  input  wire        reg_wr,            // write strobe
  input  wire        reg_rd,            // read strobe
  output reg  [31:0] reg_rdata,         // read data, cycle after strobe
  input  wire        upstream_strap,    // pin: high on the upstream port
  input  wire [7:0]  local_tick_ns,     // local time-source period, ns
  output wire        tm_active,         // time measurement permitted
  output wire        tm_root,           // acting as time root
  input  wire        l1_entry_sw,       // pulse: software-managed L1 entry
  input  wire        l1_entry_hw,       // pulse: ASPM L1 entry
  input  wire        l1_exit,           // pulse: leave L1 for L0
  input  wire        clock_request_n_in, // pin level of the shared line
  output wire        clock_request_n_out, // driven level, always low
  output wire        clock_request_n_oe, // high while pulling the line low
  output wire        in_l1_sub,         // port rests in L1.1
  output wire        wait_expired       // pulse: partner never released
);

  //////////////////////////////////////////////////////////////////////
  // declarations

  reg        strap_s1;                  // strap sync stage one
  reg        strap_s2;                  // strap sync stage two
  reg        clkreq_s1;                 // line sync stage one
  reg        clkreq_s2;                 // line sync stage two

  reg        ctl_en;                    // time measurement enable
  reg        ctl_root;                  // root select
  reg [7:0]  ctl_acc;                   // effective accuracy, storage only
  reg [7:0]  tick_ns;                   // read-only local tick period
  reg [19:0] crw_wait;                  // partner release wait, 10 ns units
  reg [15:0] dly_sw;                    // software entry delay, 4 ns units
  reg [15:0] dly_hw;                    // hardware entry delay, 4 ns units
  reg [31:0] spare2;                    // spare control word
  reg [31:0] spare3;                    // spare control word
  reg [31:0] spare4;                    // spare control word

  reg [3:0]  state;                     // power substate, one-hot
  reg [3:0]  next_state;                // next power substate
  reg        drive;                     // pulling the shared line low
  reg        next_drive;                // next drive value
  reg        use_hw;                    // current L1 came from ASPM
  reg        next_use_hw;               // next entry kind
  reg        dly_load;                  // restart entry delay timer
  reg        wait_load;                 // restart partner wait timer
  reg        dly_stop;                  // abandon entry delay
  reg        wait_stop;                 // abandon partner wait

  wire       is_up;                     // synchronised upstream strap
  wire       line_free;                 // nobody pulls the line low
  wire       dly_done;                  // entry delay expired
  wire       wait_done;                 // partner wait expired
  wire [15:0] dly_sel;                  // delay field for this entry
  wire [23:0] dly_ns;                   // entry delay in ns
  wire [23:0] wait_ns;                  // partner wait in ns
  wire       up_wr;                     // write hits an upstream register

  localparam [23:0] DLY_UNIT = `TML1_DLY_UNIT_NS; // ns per delay count
  localparam [23:0] CRW_UNIT = `TML1_CRW_UNIT_NS; // ns per wait count

  //////////////////////////////////////////////////////////////////////
  // input synchronisers; first stage feeds only the second

  // strap and shared line both come straight from pins
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_s1  <= 1'b0;
      strap_s2  <= 1'b0;
      clkreq_s1 <= 1'b1;
      clkreq_s2 <= 1'b1;
    end
    else
    begin
      strap_s1  <= upstream_strap;
      strap_s2  <= strap_s1;
      clkreq_s1 <= clock_request_n_in;
      clkreq_s2 <= clkreq_s1;
    end
  end

  assign is_up     = strap_s2;
  // wired-or: high only once our pull and the partner's both stop
  assign line_free = clkreq_s2 && !drive; // [R10]

  //////////////////////////////////////////////////////////////////////
  // time measurement role outputs

  // downstream ports carry no such structure, so no role either
  assign tm_active = is_up && ctl_en;              // [R6] [R15]
  assign tm_root   = is_up && ctl_en && ctl_root;  // [R7] [R15]

  //////////////////////////////////////////////////////////////////////
  // register writes

  assign up_wr = reg_wr && is_up;       // [R15]

  // control fields; accuracy is kept but steers nothing
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_en   <= 1'b0;                 // [R6]
      ctl_root <= 1'b0;                 // [R7]
      ctl_acc  <= 8'h00;                // [R8]
      tick_ns  <= 8'h00;                // [R5]
    end
    else
    begin
      tick_ns <= local_tick_ns;         // [R5]
      if (up_wr && reg_addr == `TML1_OFS_CTL)
      begin
        ctl_en   <= reg_wdata[`TML1_CTL_EN_BIT];   // [R6]
        ctl_root <= reg_wdata[`TML1_CTL_ROOT_BIT]; // [R7]
        ctl_acc  <= reg_wdata[`TML1_CTL_ACC_MSB:`TML1_CTL_ACC_LSB]; // [R8]
      end
    end
  end

  // vendor timing and spare words, present on every port
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      crw_wait <= WAIT_RESET;           // [R12]
      dly_sw   <= `TML1_DLY_SW_RST;     // [R13]
      dly_hw   <= `TML1_DLY_HW_RST;     // [R14]
      spare2   <= `TML1_SPR2_RST;
      spare3   <= `TML1_SPR3_RST;
      spare4   <= `TML1_SPR4_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `TML1_OFS_CRW:
          crw_wait <= reg_wdata[`TML1_CRW_MSB:0];  // [R12]
        `TML1_OFS_DLY:
        begin
          dly_sw <= reg_wdata[`TML1_DLY_SW_MSB:`TML1_DLY_SW_LSB]; // [R13]
          dly_hw <= reg_wdata[`TML1_DLY_HW_MSB:`TML1_DLY_HW_LSB]; // [R14]
        end
        `TML1_OFS_SPR2: spare2 <= reg_wdata;
        `TML1_OFS_SPR3: spare3 <= reg_wdata;
        `TML1_OFS_SPR4: spare4 <= reg_wdata;
        default:        spare2 <= spare2; // unmapped writes dropped
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register reads; answer lands in the cycle after the strobe

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 32'h00000000;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `TML1_OFS_HDR:
          reg_rdata <= is_up ? {`TML1_HDR_NEXT, `TML1_HDR_VER,
                                `TML1_HDR_ID}      // [R1] [R2] [R3]
                             : 32'h00000000;        // [R15]
        `TML1_OFS_CAP:
          reg_rdata <= is_up ? {16'h0000, tick_ns, 5'h00,
                                `TML1_CAP_ROLES}   // [R4] [R5]
                             : 32'h00000000;        // [R15]
        `TML1_OFS_CTL:
          reg_rdata <= is_up ? {16'h0000, ctl_acc, 6'h00,
                                ctl_root, ctl_en}  // [R6] [R7] [R8]
                             : 32'h00000000;        // [R15]
        `TML1_OFS_CRW:  reg_rdata <= {12'h000, crw_wait};
        `TML1_OFS_DLY:  reg_rdata <= {dly_hw, dly_sw};
        `TML1_OFS_SPR2: reg_rdata <= spare2;
        `TML1_OFS_SPR3: reg_rdata <= spare3;
        `TML1_OFS_SPR4: reg_rdata <= spare4;
        default:        reg_rdata <= 32'h00000000; // unmapped reads zero
      endcase
    end
    else
    begin
      reg_rdata <= 32'h00000000;        // data stands one cycle only
    end
  end

  //////////////////////////////////////////////////////////////////////
  // timer spans; fields are re-read at each load, not mid-count

  assign dly_sel = next_use_hw ? dly_hw : dly_sw;  // [R13] [R14]
  assign dly_ns  = {8'h00, dly_sel} * DLY_UNIT;    // [R13] [R14]
  assign wait_ns = crw_wait * CRW_UNIT;            // [R12]
  // 20-bit field times ten can reach 24 bits exactly, no overflow

  // entry delay before L1.1
  tml1_ns_timer #(.W(24)) u_dly_timer
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (dly_load),
    .stop    (dly_stop),
    .span_ns (dly_ns),
    .done    (dly_done)
  );

  // wait for the partner to let go of the line
  tml1_ns_timer #(.W(24)) u_wait_timer
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (wait_load),
    .stop    (wait_stop),
    .span_ns (wait_ns),
    .done    (wait_done)
  );

  //////////////////////////////////////////////////////////////////////
  // power substate sequencing

  // next-state logic; outside L0 an exit request outranks every other event
  always @*
  begin
    next_state  = state;
    next_drive  = drive;
    next_use_hw = use_hw;
    dly_load    = 1'b0;
    wait_load   = 1'b0;
    dly_stop    = 1'b0;
    wait_stop   = 1'b0;
    case (state)
      `TML1_ST_L0:
      begin
        next_drive = 1'b1;
        if (l1_entry_sw || l1_entry_hw)
        begin
          next_use_hw = l1_entry_hw && !l1_entry_sw;
          next_state  = `TML1_ST_L1;
          dly_load    = 1'b1;            // [R16]
        end
      end
      `TML1_ST_L1:
      begin
        if (l1_exit)
        begin
          next_state = `TML1_ST_L0;
          dly_stop   = 1'b1;
        end
        else if (dly_done)             // [R13] [R14]
        begin
          next_state = `TML1_ST_REL;
          next_drive = 1'b0;            // [R9]
          wait_load  = 1'b1;            // [R16]
        end
      end
      `TML1_ST_REL:
      begin
        if (l1_exit)
        begin
          next_state = `TML1_ST_L0;
          next_drive = 1'b1;
          wait_stop  = 1'b1;
        end
        else if (clkreq_s2)            // [R10]
        begin
          next_state = `TML1_ST_L11;
          wait_stop  = 1'b1;
        end
        else if (wait_done)
        begin
          // partner still holds the line: pull it again, retry later
          next_state = `TML1_ST_L1;     // [R11]
          next_drive = 1'b1;            // [R11]
          dly_load   = 1'b1;            // [R16]
        end
      end
      `TML1_ST_L11:
      begin
        if (l1_exit)
        begin
          next_state = `TML1_ST_L0;
          next_drive = 1'b1;
        end
        else if (!clkreq_s2)
        begin
          // partner woke the clock; fall back to L1 and hold it
          next_state = `TML1_ST_L1;
          next_drive = 1'b1;
          dly_load   = 1'b1;            // [R16]
        end
      end
      default:
      begin
        next_state = `TML1_ST_L0;
        next_drive = 1'b1;
      end
    endcase
  end

  // state flops; line is held low from reset until the entry delay expires in L1
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state  <= `TML1_ST_L0;
      drive  <= 1'b1;
      use_hw <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      drive  <= next_drive;            // [R9] [R11]
      use_hw <= next_use_hw;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin and status outputs

  // open-drain: only ever pull low, never drive high
  assign clock_request_n_out = 1'b0;   // [R10]
  assign clock_request_n_oe  = drive;  // [R9]
  assign in_l1_sub           = state[3] && line_free;
  assign wait_expired        = (state == `TML1_ST_REL) && !l1_exit &&
                               !clkreq_s2 && wait_done; // [R11]

endmodule

//--- hw/tml1_consts.vh
// offsets, field positions, reset values and timing for the tml1 block
`ifndef TML1_CONSTS_VH
`define TML1_CONSTS_VH

// register byte offsets
`define TML1_OFS_HDR        12'h260
`define TML1_OFS_CAP        12'h264
`define TML1_OFS_CTL        12'h268
`define TML1_OFS_CRW        12'h300
`define TML1_OFS_DLY        12'h304
`define TML1_OFS_SPR2       12'h308
`define TML1_OFS_SPR3       12'h30c
`define TML1_OFS_SPR4       12'h310

// capability header fields
`define TML1_HDR_ID         16'h001f
`define TML1_HDR_VER        4'h1
`define TML1_HDR_NEXT       12'h000

// capability role bits 2:0 and tick field 15:8
`define TML1_CAP_ROLES      3'h7
`define TML1_CAP_TICK_LSB   8
`define TML1_CAP_TICK_MSB   15

// control fields
`define TML1_CTL_EN_BIT     0
`define TML1_CTL_ROOT_BIT   1
`define TML1_CTL_ACC_LSB    8
`define TML1_CTL_ACC_MSB    15

// wait and delay field positions
`define TML1_CRW_MSB        19
`define TML1_DLY_SW_LSB     0
`define TML1_DLY_SW_MSB     15
`define TML1_DLY_HW_LSB     16
`define TML1_DLY_HW_MSB     31

// reset values
`define TML1_CRW_RST        20'h00fff
`define TML1_DLY_SW_RST     16'h01ff
`define TML1_DLY_HW_RST     16'h01ff
`define TML1_SPR2_RST       32'h00000000
`define TML1_SPR3_RST       32'h00000000
`define TML1_SPR4_RST       32'h000fffff

// timing: clock period and field units, all in ns
`define TML1_CLK_NS         5
`define TML1_DLY_UNIT_NS    4
`define TML1_CRW_UNIT_NS    10

// power state codes, one-hot
`define TML1_ST_L0          4'h1
`define TML1_ST_L1          4'h2
`define TML1_ST_REL         4'h4
`define TML1_ST_L11         4'h8

`endif

//--- hw/tml1_ns_timer.v
// one-shot down timer that counts a span of nanoseconds in clock steps
`timescale 1ns/10ps
`include "tml1_consts.vh"
module tml1_ns_timer
#(
  parameter W = 24                      // width of the ns budget
)
(
  input  wire         ref_clk,          // core clock
  input  wire         rst,              // async reset, active high
  input  wire         load,             // restart with a new span
  input  wire         stop,             // abandon the running span
  input  wire [W-1:0] span_ns,          // span to time, in ns
  output wire         done              // one-cycle pulse at expiry
);

  localparam [W-1:0] STEP = `TML1_CLK_NS; // ns elapsed per clock

  reg [W-1:0] remain;                   // ns still to run
  reg         running;                  // span in progress

  // expiry when the last partial step is taken; rounds the span up
  // load and stop stay out of done: the sequencer loads only idle
  // timers and ranks a stop above done, and this keeps the path
  // from load through done back into the sequencer loop-free
  assign done = running && (remain <= STEP);

  //////////////////////////////////////////////////////////////////////
  // countdown; a reload always wins so each entry starts afresh
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      remain  <= {W{1'b0}};
      running <= 1'b0;
    end
    else if (load)
    begin
      remain  <= span_ns;
      running <= 1'b1;
    end
    else if (stop || done)
    begin
      running <= 1'b0;
    end
    else if (running)
    begin
      remain <= remain - STEP;
    end
  end

endmodule

//--- sim/tml1_regs_sva.sv
// concurrent checks on the ports of the tml1 register bank
`timescale 1ns/10ps
module tml1_regs_sva
#(
  parameter [19:0] WAIT_RESET = 20'h00fff // same as the bank
)
(
  input wire        ref_clk,             // core clock
  input wire        rst,                 // async reset
  input wire [11:0] reg_addr,            // register address
  input wire [31:0] reg_wdata,           // write data
  input wire        reg_wr,              // write strobe
  input wire        reg_rd,              // read strobe
  input wire [31:0] reg_rdata,           // read data
  input wire        upstream_strap,      // upstream pin
  input wire [7:0]  local_tick_ns,       // tick period
  input wire        tm_active,           // measurement permitted
  input wire        tm_root,             // root role
  input wire        l1_entry_sw,         // software entry
  input wire        l1_entry_hw,         // hardware entry
  input wire        l1_exit,             // exit pulse
  input wire        clock_request_n_in,  // line level
  input wire        clock_request_n_out, // driven level
  input wire        clock_request_n_oe,  // pulling low
  input wire        in_l1_sub,           // resting in L1.1
  input wire        wait_expired         // partner wait timeout
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////
  // register read path; tm_active proves the strap is seen
  hdr_value_a: assert property (reg_rd && reg_addr == 12'h260 && tm_active
    |=> reg_rdata == 32'h0001001f) else $error("header word wrong");
  role_bits_a: assert property (reg_rd && reg_addr == 12'h264 && tm_active
    |=> reg_rdata[7:0] == 8'h07 && reg_rdata[31:16] == 16'h0000)
    else $error("role bits wrong");
  enable_read_a: assert property (reg_rd && reg_addr == 12'h268
    && tm_active |=> reg_rdata[0]) else $error("enable bit lost");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  // a write that leaves enable or select clear must drop the root role
  root_needs_en_a: assert property (reg_wr && reg_addr == 12'h268
    && tm_active && !(reg_wdata[0] && reg_wdata[1]) |=> !tm_root)
    else $error("root without enable and select");
  ////////////////////////////////////////////////////////////////////
  // open-drain line handling
  od_low_only_a: assert property (clock_request_n_out == 1'b0)
    else $error("line driven high");
  // the line reaches the state two edges late, so look back two
  sub_released_a: assert property (in_l1_sub |-> !clock_request_n_oe
    && $past(clock_request_n_in, 2))
    else $error("L1.1 with line held");
  expiry_redrive_a: assert property (wait_expired |-> !clock_request_n_oe
    ##1 clock_request_n_oe) else $error("no redrive after expiry");
  exit_drive_a: assert property (l1_exit && !clock_request_n_oe
    |=> clock_request_n_oe && !in_l1_sub)
    else $error("exit left line released");
  ////////////////////////////////////////////////////////////////////
  // main scenarios reached
  c_sub: cover property ($rose(in_l1_sub));
  c_exp: cover property (wait_expired);
  c_root: cover property (tm_root);
endmodule

//--- sim/tml1_link_partner.sv
// link partner side of the shared open-drain clock request line
`timescale 1ns/10ps
module tml1_link_partner
(
  input  wire ref_clk,   // core clock
  input  wire hold_req,  // bench: partner still needs the clock
  output reg  line_oe    // partner pulling the line low
);
  // partner only ever pulls low; the pull-up gives the high level
  // so a released line never shows a stale value
  initial line_oe = 1'b1;
  // changes just after the edge, like a real synchronous partner
  always @(posedge ref_clk)
    line_oe <= hold_req;
endmodule

//--- sim/tml1_regs_tb_top.sv
// directed bench for the tml1 register bank and L1.1 timing
`timescale 1ns/10ps
module tml1_regs_tb_top;
  reg         ref_clk = 1'b0;           // core clock
  reg         rst = 1'b1;               // async reset
  reg  [11:0] reg_addr = 12'h000;       // bus address
  reg  [31:0] reg_wdata = 32'h0;        // bus write data
  reg         reg_wr = 1'b0;            // write strobe
  reg         reg_rd = 1'b0;            // read strobe
  wire [31:0] reg_rdata;                // read data
  reg         strap = 1'b1;             // upstream port strap
  reg  [7:0]  tick = 8'h5a;             // local tick period
  reg         e_sw = 1'b0;              // software entry
  reg         e_hw = 1'b0;              // hardware entry
  reg         ex = 1'b0;                // exit
  reg         hold = 1'b1;              // partner holds the line
  wire        d_oe, d_out, p_oe, act, root, sub, expd;
  wire        line = (d_oe | p_oe) ? 1'b0 : 1'b1; // pull-up
  integer     error_cnt = 0;            // mismatches
  integer     n_checks = 0;             // comparisons
  integer     cyc = 0;                  // timeout counter
  reg  [31:0] d;                        // read scratch
  integer     n;                        // cycle count scratch
  ////////////////////////////////////////////////////////////////////
  tml1_regs #(.WAIT_RESET(20'h00010)) dut_u (.ref_clk(ref_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .upstream_strap(strap), .local_tick_ns(tick), .tm_active(act),
    .tm_root(root), .l1_entry_sw(e_sw), .l1_entry_hw(e_hw),
    .l1_exit(ex), .clock_request_n_in(line),
    .clock_request_n_out(d_out), .clock_request_n_oe(d_oe),
    .in_l1_sub(sub), .wait_expired(expd));
  tml1_link_partner prt_u (.ref_clk(ref_clk), .hold_req(hold),
    .line_oe(p_oe));
  initial forever #2.5 ref_clk = ~ref_clk;
  // hang guard: the tests need well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [11:0] a, input [31:0] v);
  begin
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [11:0] a);
  begin
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  end
  endtask
  // pulse one power event for one cycle
  task pulse(input integer k);
  begin
    @(posedge ref_clk);
    if (k == 0) e_sw <= 1'b1; else if (k == 1) e_hw <= 1'b1;
    else ex <= 1'b1;
    @(posedge ref_clk);
    e_sw <= 1'b0; e_hw <= 1'b0; ex <= 1'b0;
  end
  endtask
  // count edges until the port releases or a flag shows
  task wait_for(input integer k);
  begin
    n = 0;
    while (n < 100 && ((k == 0 && d_oe !== 1'b0) ||
           (k == 1 && sub !== 1'b1) || (k == 2 && expd !== 1'b1)))
    begin
      @(posedge ref_clk);
      #1 n = n + 1;
    end
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////
  // reset values, read-only fields and unmapped space
  task t_reset;
  begin
    rd(12'h260); chk(d, 32'h0001001f);
    rd(12'h264); chk(d, 32'h00005a07);
    rd(12'h268); chk(d, 32'h0);
    rd(12'h300); chk(d, 32'h00000010);
    rd(12'h304); chk(d, 32'h01ff01ff);
    rd(12'h308); chk(d, 32'h0);
    rd(12'h30c); chk(d, 32'h0);
    rd(12'h310); chk(d, 32'h000fffff);
    rd(12'h314); chk(d, 32'h0);
    $display("test reset done");
  end
  endtask
  // control bits, root select and read-only writes
  task t_ctl;
  begin
    wr(12'h260, 32'hffffffff); wr(12'h264, 32'hffffffff);
    rd(12'h260); chk(d, 32'h0001001f);
    rd(12'h264); chk(d, 32'h00005a07);
    wr(12'h268, 32'hffffffff);
    rd(12'h268); chk(d, 32'h0000ff03);
    chk({act, root}, 2'b11);
    wr(12'h268, 32'h0000ab01); #1;
    chk({act, root}, 2'b10);
    wr(12'h268, 32'h00000002); #1;
    chk({act, root}, 2'b00);
    wr(12'h300, 32'hffffffff);
    rd(12'h300); chk(d, 32'h000fffff);
    wr(12'h310, 32'h12345678);
    rd(12'h310); chk(d, 32'h12345678);
    $display("test ctl done");
  end
  endtask
  // downstream strap hides the capability registers
  task t_down;
  begin
    wr(12'h268, 32'h00000003);
    strap <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(12'h260); chk(d, 32'h0);
    rd(12'h304); chk(d, 32'h01ff01ff);
    chk({act, root}, 2'b00);
    strap <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk({act, root}, 2'b11);
    rd(12'h260); chk(d, 32'h0001001f);
    rd(12'h264); chk(d, 32'h00005a07);
    $display("test down done");
  end
  endtask
  // entry delays, prompt partner release, exit
  task t_sub;
  begin
    wr(12'h304, 32'h00030002); wr(12'h300, 32'h00000005);
    hold <= 1'b0;
    pulse(0); wait_for(0); chk(n, 2);
    wait_for(1); chk(sub, 1'b1);
    pulse(2); #1 chk({d_oe, sub}, 2'b10);
    pulse(1); wait_for(0); chk(n, 3);
    pulse(2);
    $display("test sub done");
  end
  endtask
  // partner keeps holding: timeout, redrive, fresh delay, then release
  task t_wait;
  begin
    hold <= 1'b1;
    pulse(1); wait_for(0); chk(n, 3);
    // pulse stands in the tenth cycle of the wait: nine edges before it
    wait_for(2); chk(n, 9);
    @(posedge ref_clk);
    #1 chk({d_oe, sub}, 2'b10);
    wait_for(0); chk(n, 3);
    hold <= 1'b0;
    wait_for(1); chk(sub, 1'b1);
    hold <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk({d_oe, sub}, 2'b10);
    pulse(2);
    $display("test wait done");
  end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_ctl;
    t_down;
    t_sub;
    t_wait;
    wrap_up;
  end
endmodule
bind tml1_regs tml1_regs_sva #(.WAIT_RESET(WAIT_RESET)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .upstream_strap(upstream_strap),
  .local_tick_ns(local_tick_ns), .tm_active(tm_active),
  .tm_root(tm_root), .l1_entry_sw(l1_entry_sw),
  .l1_entry_hw(l1_entry_hw), .l1_exit(l1_exit),
  .clock_request_n_in(clock_request_n_in),
  .clock_request_n_out(clock_request_n_out),
  .clock_request_n_oe(clock_request_n_oe), .in_l1_sub(in_l1_sub),
  .wait_expired(wait_expired));
